// ### logic/wsam_defines.svh
/*
  Constants of the wind speed alarm monitor: register map, field
  positions, reset values, unit limits and timing figures.
  Assumes a 100 MHz pclk and an APB master with 32-bit data.
*/
// Summary of operation
// - Imperial units: alert threshold at most 31, alarm at most 45 mph.
// - Metric units: alert threshold at most 50, alarm at most 72 km/h.
// - Threshold above its limit is replaced by that limit.
// - Filter delay is clamped to twenty seconds at most.
// - Speed must stay above threshold for whole filter delay before raising.
// - Filtered speed above alert threshold: yellow lamp blinks, horn pulses.
// - Filtered speed above alarm threshold: red, yellow and horn steadily on.
// - Lamp test drives indicators regardless of wind speed.
// - Eight hours without anemometer signal raises an alarm.
// - Indication is withdrawn only after speed stays low for filter delay.
// - Eleven newest time-stamped alarm events kept, index 0 newest.
// - Enable low forces echo, lamps, horn, alarm flag low, code zero.
// - Rising edge of lamp test lights yellow, red and horn for 6 s.
// - Filter delay counts tenths of a second, default fifty.
// - Alarm code bit0 silence, bit1 alert clamped, bit2 alarm clamped.
`ifndef WSAM_DEFINES_SVH
`define WSAM_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define WSAM_OFF_CTRL 8'h00
`define WSAM_OFF_ALERT_THR 8'h04
`define WSAM_OFF_ALARM_THR 8'h08
`define WSAM_OFF_FILTER 8'h0C
`define WSAM_OFF_BLINK 8'h10
`define WSAM_OFF_STATUS 8'h14
`define WSAM_OFF_IRQ_STATUS 8'h18
`define WSAM_OFF_IRQ_MASK 8'h1C
`define WSAM_OFF_SPEED 8'h20
`define WSAM_OFF_LOG 8'h40
`define WSAM_LOG_DEPTH 11

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WSAM_CTRL_ENABLE 0
`define WSAM_CTRL_IMPERIAL 1
`define WSAM_CTRL_LAMP_TEST 2
`define WSAM_ST_ECHO 0
`define WSAM_ST_YELLOW 1
`define WSAM_ST_RED 2
`define WSAM_ST_HORN 3
`define WSAM_ST_ALARM 4
`define WSAM_ST_ALERT_LVL 5
`define WSAM_ST_ALARM_LVL 6
`define WSAM_ST_CODE_LSB 16
`define WSAM_CODE_SILENT 0
`define WSAM_CODE_ALERT_CLAMP 1
`define WSAM_CODE_ALARM_CLAMP 2
`define WSAM_IRQ_ALERT 0
`define WSAM_IRQ_ALARM 1
`define WSAM_IRQ_SILENT 2
`define WSAM_IRQ_BITS 3

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define WSAM_FILTER_RESET 16'h0032
`define WSAM_BLINK_RESET 32'h02FAF080
`define WSAM_ALERT_MAX_MPH 16'h001F
`define WSAM_ALARM_MAX_MPH 16'h002D
`define WSAM_ALERT_MAX_KMH 16'h0032
`define WSAM_ALARM_MAX_KMH 16'h0048

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WSAM_CLK_PERIOD_NS 10
`define WSAM_TENTH_NS 100000000
`define WSAM_TENTHS_PER_S 16'h000A
`define WSAM_FILTER_MAX_S 16'h0014
`define WSAM_LAMP_TEST_S 16'h0006
`define WSAM_SILENCE_HOURS 8
`define WSAM_NS_PER_HOUR 64'h0000_0346_30B8_A000

`endif

// ### logic/wsam_pkg.sv
/*
  Types shared by the wind speed alarm monitor.
  Assumes nothing beyond a SystemVerilog tool.
*/
`default_nettype none
package wsam_pkg;
  typedef logic [15:0] wsam_speed_t;
  typedef logic [31:0] wsam_word_t;
  typedef logic [15:0] wsam_tenths_t;
endpackage : wsam_pkg
`default_nettype wire

// ### logic/wsam_top.sv
/*
  Wind speed alarm monitor with APB register access, filtered
  alert and alarm levels, lamp test, silence watchdog and event log.
  Assumes wind_speed_in and anemometer_pulse come from pins,
  datetime_in comes from logic on pclk.
*/
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "wsam_defines.svh"

module wsam_top
  import wsam_pkg::*;
#(
  parameter logic [31:0] TENTH_CYCLES =
    32'(`WSAM_TENTH_NS / `WSAM_CLK_PERIOD_NS),
  parameter logic [47:0] SILENCE_CYCLES =
    48'(64'(`WSAM_SILENCE_HOURS) * `WSAM_NS_PER_HOUR
        / 64'(`WSAM_CLK_PERIOD_NS))
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] wind_speed_in,
  input wire logic anemometer_pulse,
  input wire logic [31:0] datetime_in,
  output logic enable_echo,
  output logic yellow_lamp,
  output logic red_lamp,
  output logic horn_out,
  output logic alarm_flag,
  output logic [15:0] alarm_code,
  output logic irq
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic wsam_speed_t clamp(input wsam_speed_t v,
                                        input wsam_speed_t lim);
    clamp = (v > lim) ? lim : v;
  endfunction : clamp

  function automatic logic hit_at(input logic [7:0] a,
                                  input logic [7:0] off);
    hit_at = (a == off);
  endfunction : hit_at

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [2:0] ctrl;
  wsam_speed_t alert_thr;
  wsam_speed_t alarm_thr;
  wsam_tenths_t filter_delay;
  wsam_word_t blink_half;
  logic [`WSAM_IRQ_BITS-1:0] irq_status;
  logic [`WSAM_IRQ_BITS-1:0] irq_mask;
  wsam_word_t event_log [0:`WSAM_LOG_DEPTH-1];
  wsam_speed_t spd_s1;
  wsam_speed_t spd_s2;
  logic pul_s1;
  logic pul_s2;
  logic pul_s3;
  logic [31:0] tenth_cnt;
  wsam_word_t blink_cnt;
  logic blink_phase;
  logic [47:0] silence_cnt;
  logic silent;
  logic lamp_req_d;
  wsam_tenths_t lamp_cnt;
  logic [1:0] level;
  wsam_tenths_t filt_cnt [0:1];

  // ----------------------------------------------------------------
  // Threshold and delay limits
  // ----------------------------------------------------------------
  wire imperial = ctrl[`WSAM_CTRL_IMPERIAL];
  wire enabled = ctrl[`WSAM_CTRL_ENABLE];
  wire wsam_speed_t alert_lim = imperial ? `WSAM_ALERT_MAX_MPH
                                         : `WSAM_ALERT_MAX_KMH;
  wire wsam_speed_t alarm_lim = imperial ? `WSAM_ALARM_MAX_MPH
                                         : `WSAM_ALARM_MAX_KMH;
  wire wsam_speed_t alert_eff = clamp(alert_thr, alert_lim);
  wire wsam_speed_t alarm_eff = clamp(alarm_thr, alarm_lim);
  wire wsam_tenths_t delay_max = 16'(`WSAM_FILTER_MAX_S
                                     * `WSAM_TENTHS_PER_S);
  wire wsam_tenths_t delay_eff = clamp(filter_delay, delay_max);
  wire wsam_tenths_t lamp_tenths = 16'(`WSAM_LAMP_TEST_S
                                       * `WSAM_TENTHS_PER_S);
  wire [1:0] over = {spd_s2 > alarm_eff, spd_s2 > alert_eff};

  // ----------------------------------------------------------------
  // Timebases and edges
  // ----------------------------------------------------------------
  wire tick = (tenth_cnt == (TENTH_CYCLES - 32'h1));
  wire blink_wrap = (blink_cnt + 32'h1 >= blink_half);
  wire pulse_edge = pul_s2 ^ pul_s3;
  wire silence_hit = (silence_cnt == (SILENCE_CYCLES - 48'h1));
  wire lamp_req = ctrl[`WSAM_CTRL_LAMP_TEST];
  wire lamp_rise = lamp_req & ~lamp_req_d;

  // ----------------------------------------------------------------
  // Output decision
  // ----------------------------------------------------------------
  wire lamp_on = (lamp_cnt != 16'h0000);
  wire pulsing = level[0] & blink_phase;
  wire next_yellow = enabled & (level[1] | pulsing | lamp_on);
  wire next_red = enabled & (level[1] | lamp_on);
  wire next_horn = enabled & (level[1] | pulsing | lamp_on);
  wire next_alarm_flag = enabled & (level[1] | silent);
  wire [15:0] raw_code = 16'({alarm_thr > alarm_lim,
                              alert_thr > alert_lim,
                              silent});
  wire [15:0] next_alarm_code = enabled ? raw_code : 16'h0000;
  wire alarm_rise = next_alarm_flag & ~alarm_flag;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire [7:0] log_rel = paddr - `WSAM_OFF_LOG;
  wire [5:0] log_idx = log_rel[7:2];
  wire log_hit = (paddr >= `WSAM_OFF_LOG) & (log_rel[1:0] == 2'b00)
                 & (log_idx < 6'(`WSAM_LOG_DEPTH));
  wire h_ctrl = hit_at(paddr, `WSAM_OFF_CTRL);
  wire h_alert = hit_at(paddr, `WSAM_OFF_ALERT_THR);
  wire h_alarm = hit_at(paddr, `WSAM_OFF_ALARM_THR);
  wire h_filter = hit_at(paddr, `WSAM_OFF_FILTER);
  wire h_blink = hit_at(paddr, `WSAM_OFF_BLINK);
  wire h_status = hit_at(paddr, `WSAM_OFF_STATUS);
  wire h_istat = hit_at(paddr, `WSAM_OFF_IRQ_STATUS);
  wire h_imask = hit_at(paddr, `WSAM_OFF_IRQ_MASK);
  wire h_speed = hit_at(paddr, `WSAM_OFF_SPEED);
  wire any_hit = h_ctrl | h_alert | h_alarm | h_filter | h_blink
                 | h_status | h_istat | h_imask | h_speed | log_hit;
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire wsam_word_t status_word =
    32'({alarm_code, 9'h000, level, alarm_flag, horn_out,
         red_lamp, yellow_lamp, enable_echo});
  wire wsam_word_t log_word =
    log_hit ? event_log[4'(log_idx)] : 32'h0000_0000;
  wire wsam_word_t rd_data =
    h_ctrl ? 32'(ctrl) :
    h_alert ? 32'(alert_thr) :
    h_alarm ? 32'(alarm_thr) :
    h_filter ? 32'(filter_delay) :
    h_blink ? blink_half :
    h_status ? status_word :
    h_istat ? 32'(irq_status) :
    h_imask ? 32'(irq_mask) :
    h_speed ? 32'(spd_s2) :
    log_word;
  wire [`WSAM_IRQ_BITS-1:0] irq_events =
    {silence_hit & ~silent, over[1] & ~level[1] & (filt_cnt[1] >= delay_eff),
     over[0] & ~level[0] & (filt_cnt[0] >= delay_eff)};
  wire [`WSAM_IRQ_BITS-1:0] irq_clear =
    (wr & h_istat) ? pwdata[`WSAM_IRQ_BITS-1:0] : 3'b000;

  assign pready = 1'b1;
  assign pslverr = access & ~any_hit;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= 3'b000;
      alert_thr <= 16'h0000;
      alarm_thr <= 16'h0000;
      filter_delay <= `WSAM_FILTER_RESET;
      blink_half <= `WSAM_BLINK_RESET;
      irq_mask <= 3'b000;
    end else if (wr) begin
      if (h_ctrl) ctrl <= pwdata[2:0];
      if (h_alert) alert_thr <= pwdata[15:0];
      if (h_alarm) alarm_thr <= pwdata[15:0];
      if (h_filter) filter_delay <= pwdata[15:0];
      if (h_blink) blink_half <= pwdata;
      if (h_imask) irq_mask <= pwdata[`WSAM_IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      prdata <= rd_data;
    end
  end

  // Set wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 3'b000;
      irq <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_events;
      irq <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spd_s1 <= 16'h0000;
      spd_s2 <= 16'h0000;
      pul_s1 <= 1'b0;
      pul_s2 <= 1'b0;
      pul_s3 <= 1'b0;
    end else begin
      spd_s1 <= wind_speed_in;
      spd_s2 <= spd_s1;
      pul_s1 <= anemometer_pulse;
      pul_s2 <= pul_s1;
      pul_s3 <= pul_s2;
    end
  end

  // ----------------------------------------------------------------
  // Tenth-second prescaler and blink timebase
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tenth_cnt <= 32'h0000_0000;
    end else begin
      tenth_cnt <= tick ? 32'h0000_0000 : tenth_cnt + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt <= 32'h0000_0000;
      blink_phase <= 1'b0;
    end else if (blink_wrap) begin
      blink_cnt <= 32'h0000_0000;
      blink_phase <= ~blink_phase;
    end else begin
      blink_cnt <= blink_cnt + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Anemometer silence watchdog
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      silence_cnt <= 48'h0;
      silent <= 1'b0;
    end else if (pulse_edge) begin
      silence_cnt <= 48'h0;
      silent <= 1'b0;
    end else if (silence_hit) begin
      silent <= 1'b1;
    end else begin
      silence_cnt <= silence_cnt + 48'h1;
    end
  end

  // ----------------------------------------------------------------
  // Lamp test timer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_req_d <= 1'b0;
      lamp_cnt <= 16'h0000;
    end else begin
      lamp_req_d <= lamp_req;
      if (lamp_rise) begin
        lamp_cnt <= lamp_tenths;
      end else if (tick && lamp_on) begin
        lamp_cnt <= lamp_cnt - 16'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Gust filters, index 0 alert, index 1 alarm
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= 2'b00;
      for (int i = 0; i < 2; i++) begin
        filt_cnt[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (over[i] == level[i]) begin
          filt_cnt[i] <= 16'h0000;
        end else if (filt_cnt[i] >= delay_eff) begin
          level[i] <= over[i];
          filt_cnt[i] <= 16'h0000;
        end else if (tick) begin
          filt_cnt[i] <= filt_cnt[i] + 16'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Indicator outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_echo <= 1'b0;
      yellow_lamp <= 1'b0;
      red_lamp <= 1'b0;
      horn_out <= 1'b0;
      alarm_flag <= 1'b0;
      alarm_code <= 16'h0000;
    end else begin
      enable_echo <= enabled;
      yellow_lamp <= next_yellow;
      red_lamp <= next_red;
      horn_out <= next_horn;
      alarm_flag <= next_alarm_flag;
      alarm_code <= next_alarm_code;
    end
  end

  // ----------------------------------------------------------------
  // Alarm event log
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `WSAM_LOG_DEPTH; i++) begin
        event_log[i] <= 32'h0000_0000;
      end
    end else if (alarm_rise) begin
      event_log[0] <= datetime_in;
      for (int i = 1; i < `WSAM_LOG_DEPTH; i++) begin
        event_log[i] <= event_log[i-1];
      end
    end
  end

endmodule : wsam_top
`default_nettype wire

// ### sim/wsam_props.sv
/*
  Port checker for the wind speed alarm monitor.
  Assumes it is bound to wsam_top.
*/
`timescale 1ns/100ps
`default_nettype none
module wsam_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic enable_echo,
  input wire logic yellow_lamp,
  input wire logic red_lamp,
  input wire logic horn_out,
  input wire logic alarm_flag,
  input wire logic [15:0] alarm_code
);
  // --------------------------------------------------------------
  // Port properties
  // --------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_quiet_off:
    assert property (!enable_echo |-> !(yellow_lamp || red_lamp ||
      horn_out || alarm_flag)) else $error("indicator while disabled");
  a_code_off:
    assert property (!enable_echo |-> alarm_code == 16'h0000)
    else $error("alarm code while disabled");
  a_code_bits:
    assert property (alarm_code[15:3] == 13'h0000)
    else $error("undefined alarm code bit");
  a_red_full:
    assert property (red_lamp |-> yellow_lamp && horn_out)
    else $error("red lamp without yellow and horn");
  a_horn_sync:
    assert property ($changed(yellow_lamp) |-> $changed(horn_out))
    else $error("horn out of step with yellow");
  a_flag_red:
    assert property (alarm_flag && !alarm_code[0] |-> red_lamp)
    else $error("alarm flag without red lamp");
  a_silent_flag:
    assert property (alarm_code[0] |-> alarm_flag)
    else $error("silence without alarm flag");
  a_zero_wait:
    assert property (psel && !penable |=> pready)
    else $error("access phase not answered");
  a_err_access:
    assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
endmodule : wsam_props
bind wsam_top wsam_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .enable_echo(enable_echo), .yellow_lamp(yellow_lamp),
  .red_lamp(red_lamp), .horn_out(horn_out), .alarm_flag(alarm_flag),
  .alarm_code(alarm_code));
`default_nettype wire

// ### sim/wsam_wind_model.sv
/*
  Anemometer and lamp side of the monitor.
  Assumes the bench sets the wanted speed and whether pulses come.
*/
`timescale 1ns/100ps
`default_nettype none
module wsam_wind_model #(
  parameter int PULSE_GAP = 20
) (
  input wire logic pclk,
  input wire logic [15:0] target_speed,
  input wire logic alive,
  input wire logic yellow_lamp,
  output logic [15:0] wind_speed_in,
  output logic anemometer_pulse,
  output logic [31:0] blink_edges
);
  int gap;
  logic yellow_q;
  initial begin
    wind_speed_in = 16'h0000;
    anemometer_pulse = 1'b0;
    blink_edges = 32'h0;
    yellow_q = 1'b0;
    gap = 0;
  end
  // Speed follows target, pulses only while alive, lamp toggles counted
  always @(posedge pclk) begin
    wind_speed_in <= target_speed;
    yellow_q <= yellow_lamp;
    if (yellow_lamp !== yellow_q) begin
      blink_edges <= blink_edges + 32'h1;
    end
    gap <= (gap >= PULSE_GAP) ? 0 : gap + 1;
    if (alive && gap == PULSE_GAP) begin
      anemometer_pulse <= !anemometer_pulse;
    end
  end
endmodule : wsam_wind_model
`default_nettype wire

// ### sim/tb_wind_speed_alarm_monitor.sv
/*
  Self-checking bench of the wind speed alarm monitor.
  Assumes wsam_top, its checker and the wind model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "wsam_defines.svh"
module tb_wind_speed_alarm_monitor;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] target;
  logic alive;
  logic [15:0] wind_speed_in;
  logic anemometer_pulse;
  logic [31:0] datetime_in = 32'h0;
  logic enable_echo, yellow_lamp, red_lamp, horn_out, alarm_flag, irq;
  logic [15:0] alarm_code;
  logic [31:0] blink_edges;
  logic [31:0] rdat;
  logic rerr;
  logic flag_q = 1'b0;
  logic [31:0] dt_prev = 32'h0;
  logic [31:0] log_q[$];
  logic [15:0] lim_t[2] = '{`WSAM_ALERT_MAX_KMH, `WSAM_ALERT_MAX_MPH};
  logic [15:0] lim_a[2] = '{`WSAM_ALARM_MAX_KMH, `WSAM_ALARM_MAX_MPH};
  int errors = 0;
  int n_tests = 0;
  int n;
  int seed;
  int thr;

  wsam_top #(
    .TENTH_CYCLES(32'h0000000A),
    .SILENCE_CYCLES(48'h0000000000C8)
  ) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wind_speed_in(wind_speed_in),
    .anemometer_pulse(anemometer_pulse), .datetime_in(datetime_in),
    .enable_echo(enable_echo), .yellow_lamp(yellow_lamp),
    .red_lamp(red_lamp), .horn_out(horn_out), .alarm_flag(alarm_flag),
    .alarm_code(alarm_code), .irq(irq)
  );
  wsam_wind_model #(.PULSE_GAP(20)) u_wind (
    .pclk(pclk), .target_speed(target), .alive(alive),
    .yellow_lamp(yellow_lamp), .wind_speed_in(wind_speed_in),
    .anemometer_pulse(anemometer_pulse), .blink_edges(blink_edges)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string what, input logic [7:0] a,
                       input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rdat, exp);
  endtask : rdchk

  task automatic wait_sig(input logic code_bit, input logic v);
    n = 0;
    while ((code_bit ? alarm_code[0] : red_lamp) !== v && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    chk("wait limit", 32'(n < 5000), 32'h1);
  endtask : wait_sig

  task automatic in_span(input string what, input int lo, input int hi);
    chk(what, 32'(n >= lo && n <= hi), 32'h1);
  endtask : in_span

  // Code bits 1 and 2 from raw thresholds, silence bit left clear
  function automatic logic [31:0] exp_code(input int u, input int t,
                                           input int a);
    exp_code = 32'({a > lim_a[u], t > lim_t[u], 1'b0});
  endfunction : exp_code

  task automatic conclude;
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // Time stamp source and expected event log
  always @(posedge pclk) begin
    if (presetn && alarm_flag === 1'b1 && flag_q === 1'b0) begin
      log_q.push_front(dt_prev);
    end
    flag_q = alarm_flag;
    dt_prev = datetime_in;
    datetime_in <= $urandom;
  end

  initial begin
    repeat (40000) @(posedge pclk);
    errors++;
    conclude();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    target = 16'h0000;
    alive = 1'b1;
    seed = $urandom(32'h58593248);
    for (int i = 0; i < 11; i++) log_q.push_back(32'h0);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("filter reset", `WSAM_OFF_FILTER, 32'h00000032);
    rdchk("blink reset", `WSAM_OFF_BLINK, `WSAM_BLINK_RESET);
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped error", 32'(rerr), 32'h1);
    apb(1'b1, `WSAM_OFF_BLINK, 32'h4);
    apb(1'b1, `WSAM_OFF_FILTER, 32'h2);
    for (int u = 0; u < 2; u++) begin
      apb(1'b1, `WSAM_OFF_CTRL, 32'(1 + 2 * u));
      thr = lim_t[u] + 1 + $urandom % 99;
      apb(1'b1, `WSAM_OFF_ALERT_THR, 32'(thr));
      apb(1'b1, `WSAM_OFF_ALARM_THR, 32'h0000FFFF);
      repeat (4) @(posedge pclk);
      chk("clamp code", 32'(alarm_code),
          exp_code(u, thr, 32'hFFFF));
      target <= lim_a[u];
      repeat (100) @(posedge pclk);
      chk("red at limit", 32'(red_lamp), 32'h0);
      target <= lim_a[u] + 16'h0001;
      wait_sig(1'b0, 1'b1);
      in_span("red above limit", 10, 40);
      target <= 16'h0000;
      wait_sig(1'b0, 1'b0);
      in_span("red withdrawn", 10, 40);
      apb(1'b1, `WSAM_OFF_ALERT_THR, 32'(lim_t[u]));
      apb(1'b1, `WSAM_OFF_ALARM_THR, 32'(lim_a[u]));
      repeat (4) @(posedge pclk);
      chk("code at limit", 32'(alarm_code),
          exp_code(u, lim_t[u], lim_a[u]));
    end
    apb(1'b1, `WSAM_OFF_FILTER, 32'h5);
    target <= 16'h00FF;
    wait_sig(1'b0, 1'b1);
    in_span("filter delay", 40, 60);
    target <= 16'h0000;
    wait_sig(1'b0, 1'b0);
    target <= 16'h00FF;
    repeat (35) @(posedge pclk);
    chk("gust ignored", 32'(red_lamp), 32'h0);
    target <= 16'h0000;
    apb(1'b1, `WSAM_OFF_FILTER, 32'h0000FFFF);
    target <= 16'h00FF;
    wait_sig(1'b0, 1'b1);
    in_span("filter clamp", 1990, 2010);
    target <= 16'h0000;
    wait_sig(1'b0, 1'b0);
    in_span("clamped withdraw", 1990, 2010);
    apb(1'b1, `WSAM_OFF_FILTER, 32'h0);
    apb(1'b1, `WSAM_OFF_ALERT_THR, 32'hA);
    apb(1'b1, `WSAM_OFF_ALARM_THR, 32'h28);
    target <= 16'(11 + $urandom % 29);
    repeat (20) @(posedge pclk);
    n = blink_edges;
    repeat (40) @(posedge pclk);
    n = blink_edges - n;
    in_span("blink count", 9, 11);
    chk("alert red", 32'(red_lamp), 32'h0);
    rdchk("speed reg", `WSAM_OFF_SPEED, 32'(target));
    apb(1'b1, `WSAM_OFF_CTRL, 32'h2);
    repeat (3) @(posedge pclk);
    chk("disabled", 32'({enable_echo, yellow_lamp, red_lamp, horn_out,
      alarm_flag}), 32'h0);
    rdchk("status off", `WSAM_OFF_STATUS,
          32'h1 << `WSAM_ST_ALERT_LVL);
    target <= 16'h0000;
    apb(1'b1, `WSAM_OFF_CTRL, 32'h1);
    repeat (5) @(posedge pclk);
    apb(1'b1, `WSAM_OFF_CTRL, 32'h5);
    wait_sig(1'b0, 1'b1);
    in_span("lamp test start", 0, 5);
    wait_sig(1'b0, 1'b0);
    in_span("lamp test length", 585, 605);
    apb(1'b1, `WSAM_OFF_IRQ_MASK, 32'h7);
    apb(1'b1, `WSAM_OFF_IRQ_STATUS, 32'h7);
    repeat (3) @(posedge pclk);
    chk("irq cleared", 32'(irq), 32'h0);
    alive <= 1'b0;
    wait_sig(1'b1, 1'b1);
    in_span("silence time", 180, 240);
    repeat (2) @(posedge pclk);
    chk("silence irq", 32'(irq), 32'h1);
    rdchk("irq status", `WSAM_OFF_IRQ_STATUS, 32'h4);
    apb(1'b1, `WSAM_OFF_IRQ_MASK, 32'h3);
    repeat (3) @(posedge pclk);
    chk("irq masked", 32'(irq), 32'h0);
    alive <= 1'b1;
    apb(1'b1, `WSAM_OFF_IRQ_STATUS, 32'h4);
    apb(1'b1, `WSAM_OFF_IRQ_MASK, 32'h7);
    repeat (3) @(posedge pclk);
    chk("irq after clear", 32'(irq), 32'h0);
    repeat (30) @(posedge pclk);
    for (int e = 0; e < 8; e++) begin
      target <= 16'(41 + $urandom % 200);
      wait_sig(1'b0, 1'b1);
      target <= 16'h0000;
      wait_sig(1'b0, 1'b0);
    end
    for (int i = 0; i < 11; i++) begin
      rdchk("event log", 8'(`WSAM_OFF_LOG + 4 * i), log_q[i]);
    end
    conclude();
  end
endmodule : tb_wind_speed_alarm_monitor
`default_nettype wire
